// ---- src/toc_tx_output.sv ----
// Transmit output selection and CMI line coder for one port.
// Assumes port_tx_clock is synchronous to clk_sys and slower than half
// its rate; software feeds bytes over an Avalon-MM slave.
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "toc_regs.svh"

module toc_tx_output (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  // Avalon-MM slave
  input  wire logic [`TOC_ADDR_W-1:0]   avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  // Port transmit clock, sampled as an ordinary input
  input  wire logic                     port_tx_clock,
  // Optical single-rail output
  output logic                          optical_tx_data_out,
  output logic                          optical_tx_data_oe,
  // Analog line driver pair
  output logic                          analog_line_out_a,
  output logic                          analog_line_out_b,
  output logic                          analog_line_oe
);

  toc_pkg::toc_ctrl_t ctrl_r;
  toc_pkg::toc_mode_t mode;
  toc_pkg::toc_ser_t  ser_r;

  logic                       req;
  logic                       grant;
  logic                       done;
  logic                       data_push;
  logic                       fifo_in_ready;
  logic                       fifo_out_valid;
  logic [`TOC_FIFO_WIDTH-1:0] fifo_out_data;
  logic                       fifo_out_ready;
  logic [`TOC_LEVEL_W-1:0]    fifo_level;
  logic                       underrun_r;
  logic                       tclk_q_r;
  logic                       tx_rise;
  logic                       tx_fall;
  logic [`TOC_FIFO_WIDTH-1:0] shreg_r;
  logic [2:0]                 bitcnt_r;
  logic                       next_bit;
  logic                       cur_bit_r;
  logic                       alt_r;
  logic                       level_r;
  logic [31:0]                stat_word;

  // Bus handshake: one wait cycle, longer for a data write while the buffer is full; answer from a register
  assign req   = avs_read || avs_write;
  assign grant = req && avs_waitrequest &&
                 !(avs_write && avs_address == `TOC_DATA_OFS &&
                   !fifo_in_ready);
  assign done  = req && !avs_waitrequest;
  assign data_push = done && avs_write && avs_byteenable[0] &&
                     avs_address == `TOC_DATA_OFS;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !grant;
    end
  end

  assign stat_word = {19'h0_0000, fifo_level, 5'h00, underrun_r,
                      !fifo_in_ready, fifo_level == '0};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (grant && avs_read) begin
      if (avs_address == `TOC_CTRL_OFS) begin
        avs_readdata <= {28'h000_0000, ctrl_r};
      end else if (avs_address == `TOC_STAT_OFS) begin
        avs_readdata <= stat_word;
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r <= `TOC_CTRL_RST;
    end else if (done && avs_write && avs_byteenable[0] &&
                 avs_address == `TOC_CTRL_OFS) begin
      ctrl_r <= avs_writedata[`TOC_CTRL_W-1:0];
    end
  end

  // Mode decode; dual rail and coding together select nothing at all
  always_comb begin
    mode = toc_pkg::TOC_MODE_OFF;
    if (ctrl_r.tristate) begin
      mode = toc_pkg::TOC_MODE_OFF;
    end else if (!ctrl_r.dual_rail && ctrl_r.coding) begin
      mode = toc_pkg::TOC_MODE_ANALOG;
    end else if (ctrl_r.dual_rail && !ctrl_r.coding) begin
      mode = toc_pkg::TOC_MODE_OPTICAL;
    end
  end

  toc_fifo #(
    .WIDTH (`TOC_FIFO_WIDTH),
    .DEPTH (`TOC_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (data_push),
    .in_data   (avs_writedata[`TOC_FIFO_WIDTH-1:0]),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_out_ready),
    .level     (fifo_level)
  );

  // Edge detect on the transmit clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tclk_q_r <= 1'b0;
    end else begin
      tclk_q_r <= port_tx_clock;
    end
  end

  assign tx_rise = port_tx_clock && !tclk_q_r;
  assign tx_fall = !port_tx_clock && tclk_q_r;

  // Byte serialiser, LSB first; idle sends ones to keep the line busy
  assign fifo_out_ready = (ser_r == toc_pkg::TOC_SER_IDLE);
  assign next_bit = (ser_r == toc_pkg::TOC_SER_BYTE) ? shreg_r[0] : 1'b1;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ser_r    <= toc_pkg::TOC_SER_IDLE;
      shreg_r  <= '0;
      bitcnt_r <= 3'h0;
    end else begin
      case (ser_r)
        toc_pkg::TOC_SER_IDLE: begin
          if (fifo_out_valid) begin
            ser_r    <= toc_pkg::TOC_SER_BYTE;
            shreg_r  <= fifo_out_data;
            bitcnt_r <= 3'h0;
          end
        end
        toc_pkg::TOC_SER_BYTE: begin
          if (tx_rise) begin
            shreg_r  <= {1'b0, shreg_r[`TOC_FIFO_WIDTH-1:1]};
            bitcnt_r <= 3'(bitcnt_r + 1'b1);
            if (bitcnt_r == `TOC_BITCNT_LAST) begin
              ser_r <= toc_pkg::TOC_SER_IDLE;
            end
          end
        end
        default: begin
          ser_r <= toc_pkg::TOC_SER_IDLE;
        end
      endcase
    end
  end

  // Starved while driving the line; set wins over a write-one clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      underrun_r <= 1'b0;
    end else if (tx_rise && ser_r == toc_pkg::TOC_SER_IDLE &&
                 mode != toc_pkg::TOC_MODE_OFF) begin
      underrun_r <= 1'b1;
    end else if (done && avs_write && avs_byteenable[0] &&
                 avs_address == `TOC_STAT_OFS &&
                 avs_writedata[`TOC_STAT_UNDER_BIT]) begin
      underrun_r <= 1'b0;
    end
  end

  // CMI coder: rising edge opens a bit, falling edge is mid-bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_bit_r <= 1'b0;
      alt_r     <= 1'b0;
      level_r   <= 1'b0;
    end else if (tx_rise) begin
      cur_bit_r <= next_bit;
      if (next_bit) begin
        level_r <= !alt_r;
        alt_r   <= !alt_r;
      end else begin
        level_r <= 1'b0;
      end
    end else if (tx_fall && !cur_bit_r) begin
      level_r <= 1'b1;
    end
  end

  // Pin drivers; disabled pins also park their data low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      optical_tx_data_out <= 1'b0;
      optical_tx_data_oe  <= 1'b0;
    end else begin
      optical_tx_data_oe  <= (mode == toc_pkg::TOC_MODE_OPTICAL);
      optical_tx_data_out <= (mode == toc_pkg::TOC_MODE_OPTICAL) &&
                             (level_r ^ ctrl_r.polarity);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      analog_line_out_a <= 1'b0;
      analog_line_out_b <= 1'b0;
      analog_line_oe    <= 1'b0;
    end else begin
      analog_line_oe    <= (mode == toc_pkg::TOC_MODE_ANALOG);
      analog_line_out_a <= (mode == toc_pkg::TOC_MODE_ANALOG) && level_r;
      analog_line_out_b <= (mode == toc_pkg::TOC_MODE_ANALOG) && !level_r;
    end
  end

  sequence s_rise_zero;
    tx_rise && !next_bit;
  endsequence

  sequence s_rise_one;
    tx_rise && next_bit;
  endsequence

  a_analog_rail_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    analog_line_oe |-> $past(!ctrl_r.dual_rail))
    else $error("analog driven with dual rail select set");

  a_analog_enable: assert property (
    @(posedge clk_sys) disable iff (rst)
    analog_line_oe |-> $past(ctrl_r.coding && !ctrl_r.tristate))
    else $error("analog driven without coding set and tristate clear");

  a_one_full_period: assert property (
    @(posedge clk_sys) disable iff (rst)
    tx_fall && cur_bit_r |=> $stable(level_r))
    else $error("one bit did not hold for the whole period");

  a_optical_polarity: assert property (
    @(posedge clk_sys) disable iff (rst)
    optical_tx_data_oe |->
      optical_tx_data_out == ($past(level_r) ^ $past(ctrl_r.polarity)))
    else $error("optical data polarity wrong");

  a_optical_mode: assert property (
    @(posedge clk_sys) disable iff (rst)
    optical_tx_data_oe |-> $past(ctrl_r.dual_rail && !ctrl_r.coding))
    else $error("optical mode without dual rail set and coding clear");

  a_optical_enable: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(optical_tx_data_oe) |-> $past(!ctrl_r.tristate) && !analog_line_oe)
    else $error("optical enabled with tristate set");

  a_cmi_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_rise_zero |=> !level_r ##1 (!level_r || tx_fall || $past(tx_fall)))
    else $error("zero did not open low");

  a_cmi_one_alt: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_rise_one |=> level_r == !$past(alt_r))
    else $error("one did not alternate");

  a_wait_release: assert property (
    @(posedge clk_sys) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // The two pin groups must never fight over one transformer or fibre
  a_pins_exclusive: assert property (
    @(posedge clk_sys) disable iff (rst)
    !(optical_tx_data_oe && analog_line_oe))
    else $error("optical and analog pins driven together");

  a_parked_low: assert property (
    @(posedge clk_sys) disable iff (rst)
    !analog_line_oe |-> !analog_line_out_a && !analog_line_out_b)
    else $error("disabled analog pair not parked low");

  a_underrun_set: assert property (
    @(posedge clk_sys) disable iff (rst)
    tx_rise && ser_r == toc_pkg::TOC_SER_IDLE &&
      mode != toc_pkg::TOC_MODE_OFF |=> underrun_r)
    else $error("underrun event lost");

endmodule

// ---- src/toc_regs.svh ----
// Register offsets, field positions, reset values and sizes of the
// transmit output block. Definitions only; included by the package users.
`ifndef TOC_REGS_SVH
`define TOC_REGS_SVH

// Avalon byte addresses, one 32-bit word per register
`define TOC_ADDR_W           4
`define TOC_CTRL_OFS         4'h0
`define TOC_DATA_OFS         4'h4
`define TOC_STAT_OFS         4'h8

// Control register: bit 0 dual rail select, bit 1 coding config,
// bit 2 line tristate, bit 3 data polarity
`define TOC_CTRL_W           4
`define TOC_CTRL_RST         4'h4

// Status register fields
`define TOC_STAT_EMPTY_BIT   0
`define TOC_STAT_FULL_BIT    1
`define TOC_STAT_UNDER_BIT   2
`define TOC_STAT_LEVEL_LSB   8

// Transmit data buffer
`define TOC_FIFO_WIDTH       8
`define TOC_FIFO_DEPTH       16
`define TOC_LEVEL_W          5
`define TOC_BITCNT_LAST      3'h7

`endif

// ---- src/toc_pkg.sv ----
// Types shared by the transmit output block.
// Assumes toc_regs.svh supplies the sizes.
`include "toc_regs.svh"

package toc_pkg;

  // Control fields; dual_rail sits in bit 0
  typedef struct packed {
    logic polarity;
    logic tristate;
    logic coding;
    logic dual_rail;
  } toc_ctrl_t;

  typedef enum logic [1:0] {
    TOC_MODE_OFF     = 2'b00,
    TOC_MODE_ANALOG  = 2'b01,
    TOC_MODE_OPTICAL = 2'b10
  } toc_mode_t;

  typedef enum logic {
    TOC_SER_IDLE = 1'b0,
    TOC_SER_BYTE = 1'b1
  } toc_ser_t;

endpackage

// ---- src/toc_fifo.sv ----
// Transmit data FIFO with a registered read port.
// Assumes one clock and a power-of-two depth.
`timescale 1ns/1ps

module toc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  // Filling side
  input  wire logic                         in_valid,
  input  wire logic [WIDTH-1:0]             in_data,
  output wire logic                         in_ready,
  // Draining side
  output logic                              out_valid,
  output logic [WIDTH-1:0]                  out_data,
  input  wire logic                         out_ready,
  // Words held, output stage included
  output wire logic [$clog2(DEPTH+1)-1:0]   level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [CW-1:0]    cnt_r;
  logic             push;
  logic             load;

  assign in_ready = (cnt_r != CW'(DEPTH));
  assign push     = in_valid && in_ready;
  assign load     = (cnt_r != '0) && (!out_valid || out_ready);
  assign level    = CW'(cnt_r + CW'(out_valid));

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
    end else if (push) begin
      wp_r <= AW'(wp_r + 1'b1);
    end
  end

  // Output stage is a register so read data never come from the array
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rp_r      <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      rp_r      <= AW'(rp_r + 1'b1);
      out_valid <= 1'b1;
      out_data  <= mem[rp_r];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= CW'(cnt_r + CW'(push) - CW'(load));
    end
  end

endmodule

// ---- bench/toc_line_model.sv ----
// Far-side model: makes the port transmit clock and decodes the CMI line.
// Assumes the bench resolves the wire level from the output enables.
`timescale 1ns/1ps

module toc_line_model #(
  parameter int HALF = 6
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Bench control
  input  wire logic run,
  input  wire logic inv,
  // Line side
  input  wire logic line,
  output logic      port_tx_clock,
  // Decoded stream
  output logic      bit_vld,
  output logic      bit_val,
  output int        code_errs
);
  int   cnt;
  logic first_r;
  logic last_one_r;
  logic lvl;

  assign lvl = line ^ inv;

  // Each half is sampled late in its phase, well after the coder's latency
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt           <= 0;
      port_tx_clock <= 1'b0;
      first_r       <= 1'b0;
      last_one_r    <= 1'b0;
      bit_vld       <= 1'b0;
      bit_val       <= 1'b0;
      code_errs     <= 0;
    end else begin
      bit_vld <= 1'b0;
      if (run) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
          port_tx_clock <= ~port_tx_clock;
          if (port_tx_clock) begin
            first_r <= lvl;
          end else begin
            bit_vld <= 1'b1;
            bit_val <= (first_r == lvl);
            if (first_r == lvl) begin
              last_one_r <= lvl;
              if (lvl == last_one_r) code_errs <= code_errs + 1;
            end else if (first_r) begin
              code_errs <= code_errs + 1;
            end
          end
        end
      end
    end
  end
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the transmit output block.
// Assumes the line model drives the port clock and decodes the line.
`timescale 1ns/1ps
`include "toc_regs.svh"

module testbench;
  typedef struct packed {
    logic [3:0] c;
    logic       a;
    logic       o;
  } toc_row_t;
  localparam toc_row_t ROWS [10] = '{
    '{4'h0, 1'b0, 1'b0}, '{4'h1, 1'b0, 1'b1}, '{4'h2, 1'b1, 1'b0},
    '{4'h3, 1'b0, 1'b0}, '{4'h4, 1'b0, 1'b0}, '{4'h5, 1'b0, 1'b0},
    '{4'h6, 1'b0, 1'b0}, '{4'h7, 1'b0, 1'b0}, '{4'h9, 1'b0, 1'b1},
    '{4'hA, 1'b1, 1'b0}};

  logic        clk_sys = 1'b0;
  logic        rst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        port_tx_clock;
  logic        optical_tx_data_out;
  logic        optical_tx_data_oe;
  logic        analog_line_out_a;
  logic        analog_line_out_b;
  logic        analog_line_oe;
  logic        run;
  logic        inv;
  logic        sel_a;
  logic        line;
  logic        bit_vld;
  logic        bit_val;
  logic        refused;
  logic [31:0] q;
  logic        bits[$];
  int          errs;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;

  toc_tx_output DUT (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .port_tx_clock, .optical_tx_data_out, .optical_tx_data_oe,
    .analog_line_out_a, .analog_line_out_b, .analog_line_oe);

  toc_line_model #(.HALF(6)) u_line (.clk_sys, .rst, .run, .inv, .line,
    .port_tx_clock, .bit_vld, .bit_val, .code_errs(errs));

  // Released pins float; the model must not read a stale level
  assign line = sel_a ? (analog_line_oe ? analog_line_out_a : 1'bz)
                      : (optical_tx_data_oe ? optical_tx_data_out : 1'bz);

  always #5 clk_sys = ~clk_sys;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // A write still waiting after 40 cycles is a refusal; restarting the
  // line lets the buffer drain so the request can complete
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk_sys);
      n++;
      if (n == 40) begin
        refused = 1'b1;
        run <= 1'b1;
      end
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Bytes must have bit 0 clear so the idle ones can be skipped
  task automatic line_test(input logic [3:0] c, input logic iv,
                           input logic sa, input logic [15:0] d);
    int e0;
    int k;
    logic [31:0] r;
    bus(1'b1, `TOC_CTRL_OFS, 32'(c), r);
    inv <= iv;
    sel_a <= sa;
    repeat (60) @(posedge clk_sys);
    bits = {};
    e0 = errs;
    bus(1'b1, `TOC_DATA_OFS, 32'(d[7:0]), r);
    bus(1'b1, `TOC_DATA_OFS, 32'(d[15:8]), r);
    k = 0;
    while (bits.size() < 40 && k < 2000) begin
      @(posedge clk_sys);
      k++;
    end
    while (bits.size() > 0 && bits[0] === 1'b1) void'(bits.pop_front());
    for (int i = 0; i < 16; i++) chk1(bits[i], d[i]);
    chk32(32'(errs - e0), 32'h0000_0000);
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (bit_vld === 1'b1) bits.push_back(bit_val);
    if (analog_line_oe === 1'b1)
      chk1(analog_line_out_b, ~analog_line_out_a);
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    int k;
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    run = 1'b0;
    inv = 1'b0;
    sel_a = 1'b0;
    refused = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk1(optical_tx_data_oe, 1'b0);
    chk1(analog_line_oe, 1'b0);
    bus(1'b0, `TOC_CTRL_OFS, 32'h0, q);
    chk32(q, 32'h0000_0004);
    foreach (ROWS[i]) begin
      bus(1'b1, `TOC_CTRL_OFS, 32'(ROWS[i].c), q);
      bus(1'b0, `TOC_CTRL_OFS, 32'h0, q);
      chk32(q, 32'(ROWS[i].c));
      repeat (2) @(posedge clk_sys);
      chk1(analog_line_oe, ROWS[i].a);
      chk1(optical_tx_data_oe, ROWS[i].o);
    end
    run <= 1'b1;
    line_test(4'h1, 1'b0, 1'b0, 16'h365A);
    line_test(4'h9, 1'b1, 1'b0, 16'hA436);
    line_test(4'h2, 1'b0, 1'b1, 16'h5A36);
    // Unmapped place and a disabled byte lane leave control untouched
    bus(1'b1, 4'hC, 32'h0000_000F, q);
    bus(1'b0, 4'hC, 32'h0, q);
    chk32(q, 32'h0000_0000);
    avs_byteenable <= 4'h0;
    bus(1'b1, `TOC_CTRL_OFS, 32'h0000_0001, q);
    avs_byteenable <= 4'hF;
    bus(1'b0, `TOC_CTRL_OFS, 32'h0, q);
    chk32(q, 32'h0000_0002);
    // Stall the line, fill the buffer until it refuses, then drain it
    bus(1'b1, `TOC_CTRL_OFS, 32'h0000_0001, q);
    run <= 1'b0;
    sel_a <= 1'b0;
    for (int i = 0; i < 20 && refused == 1'b0; i++) begin
      bus(1'b0, `TOC_STAT_OFS, 32'h0, q);
      if (q[`TOC_STAT_FULL_BIT] === 1'b1) begin
        chk1(q[`TOC_STAT_EMPTY_BIT], 1'b0);
        bus(1'b1, `TOC_DATA_OFS, 32'h0000_0000, q);
      end else begin
        bus(1'b1, `TOC_DATA_OFS, 32'(i), q);
      end
    end
    chk1(refused, 1'b1);
    k = 0;
    do begin
      bus(1'b0, `TOC_STAT_OFS, 32'h0, q);
      k++;
    end while (q[`TOC_STAT_EMPTY_BIT] !== 1'b1 && k < 1000);
    chk1(q[`TOC_STAT_EMPTY_BIT], 1'b1);
    repeat (300) @(posedge clk_sys);
    bus(1'b0, `TOC_STAT_OFS, 32'h0, q);
    chk1(q[`TOC_STAT_UNDER_BIT], 1'b1);
    run <= 1'b0;
    bus(1'b1, `TOC_STAT_OFS, 32'h0000_0004, q);
    bus(1'b0, `TOC_STAT_OFS, 32'h0, q);
    chk1(q[`TOC_STAT_UNDER_BIT], 1'b0);
    // Reset in mid-run must park both pin groups and restore control
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk1(optical_tx_data_oe, 1'b0);
    chk1(analog_line_oe, 1'b0);
    bus(1'b0, `TOC_CTRL_OFS, 32'h0, q);
    chk32(q, 32'h0000_0004);
    bus(1'b0, `TOC_STAT_OFS, 32'h0, q);
    chk32(q, 32'h0000_0001);
    chk1(optical_tx_data_oe, 1'b0);
    give_verdict();
  end
endmodule
